// [logic/bcis_pkg.sv]
// Constants, opcodes and state encoding of the instruction sequencer.
package bcis_pkg;

  // ----------------------------------------------------------------------
  // Instruction list geometry and entry layout.
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int ENTRY_W = 40;
  localparam int OP_W = 8;
  localparam int LABEL_W = 16;
  localparam int PARAM_W = 16;
  localparam int OP_LSB = 32;
  localparam int LABEL_LSB = 16;
  localparam int PARAM_LSB = 0;

  // ----------------------------------------------------------------------
  // Opcodes; an all-zero entry decodes as a no-operation.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RUN_TRANSFER = 8'h01;
  localparam logic [7:0] OP_CALL_SUBTABLE = 8'h02;
  localparam logic [7:0] OP_RETURN_SUBTABLE = 8'h03;
  localparam logic [7:0] OP_ABSOLUTE_BRANCH = 8'h04;
  localparam logic [7:0] OP_RELATIVE_BRANCH = 8'h05;
  localparam logic [7:0] OP_AWAIT_TRIGGER_IN = 8'h06;
  localparam logic [7:0] OP_PULSE_TRIGGER_OUT = 8'h07;
  localparam logic [7:0] OP_COUNT_DOWN_BRANCH = 8'h08;
  localparam logic [7:0] OP_AWAIT_NEXT_SLOT = 8'h09;
  localparam logic [7:0] OP_STOP_CONTROLLER = 8'h0a;
  localparam logic [7:0] OP_TIMED_PAUSE = 8'h0b;
  localparam logic [7:0] OP_SET_SLOT_PERIOD = 8'h0c;
  localparam logic [7:0] OP_RESTART_MAJOR_CYCLE = 8'h0d;

  // ----------------------------------------------------------------------
  // Timing: pause unit and slot-period unit, as cycles of clk.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int PAUSE_UNIT_NS = 250;
  localparam int SLOT_UNIT_NS = 1000;
  localparam int PAUSE_UNIT_CYC_I =
    (PAUSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_UNIT_CYC_I = SLOT_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PAUSE_UNIT_CYC = 8'(PAUSE_UNIT_CYC_I);
  localparam logic [7:0] SLOT_UNIT_CYC = 8'(SLOT_UNIT_CYC_I);

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;

  // ----------------------------------------------------------------------
  // Sequencer states, Gray coded along the fetch and decode path.
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH = 4'h1,
    ST_DECODE = 4'h3,
    ST_XFER_WAIT = 4'h2,
    ST_TRIG_WAIT = 4'h6,
    ST_SLOT_WAIT = 4'h7,
    ST_PAUSE = 4'h5,
    ST_SRCH_RD = 4'h4,
    ST_SRCH_CHK = 4'hc,
    ST_HALT = 4'hd
  } bcis_state_type;

endpackage : bcis_pkg

// [logic/bcis_list_mem.sv]
// Instruction list memory: host write port, registered read port.
`timescale 1ns/100ps
module bcis_list_mem
  import bcis_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [bcis_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [bcis_pkg::ENTRY_W-1:0] wr_data,
  input wire logic [bcis_pkg::ADDR_W-1:0] rd_addr,
  output logic [bcis_pkg::ENTRY_W-1:0] rd_data
);

  logic [ENTRY_W-1:0] mem_q [0:(1 << ADDR_W)-1];

  // The array has no reset; the host clears it before building a table.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end

endmodule : bcis_list_mem

// [logic/bcis_sequencer.sv]
// Instruction sequencer that walks the bus controller instruction list.
`timescale 1ns/100ps
module bcis_sequencer
  import bcis_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [bcis_pkg::ADDR_W-1:0] start_addr,
  input wire logic [15:0] frame_cnt_init,
  input wire logic [15:0] frame_time_init,
  input wire logic host_wr_en,
  input wire logic [bcis_pkg::ADDR_W-1:0] host_wr_addr,
  input wire logic [bcis_pkg::ENTRY_W-1:0] host_wr_data,
  output logic xfer_req,
  output logic [15:0] xfer_id,
  input wire logic xfer_done,
  input wire logic trigger_in,
  output logic trigger_out,
  output logic running,
  output logic halted,
  output logic label_miss,
  output logic [bcis_pkg::ADDR_W-1:0] instr_addr
);

  // ----------------------------------------------------------------------
  // Reset release and helpers.
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Assertion is immediate, release waits two edges to avoid metastability.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Address of the entry after a, skipping n further entries.
  function automatic logic [ADDR_W-1:0] adv(input logic [ADDR_W-1:0] a,
                                            input logic [15:0] n);
    adv = a + n[ADDR_W-1:0] + ADDR_W'(1);
  endfunction : adv

  // ----------------------------------------------------------------------
  // State and storage.
  // ----------------------------------------------------------------------
  bcis_state_type state_q, state_d;
  logic [ADDR_W-1:0] pc_q, pc_d, ret_q, ret_d, scan_q, scan_d;
  logic [LABEL_W-1:0] target_q, target_d;
  logic [15:0] mcnt_q, mcnt_d, period_q, period_d, units_q, units_d;
  logic [15:0] xfer_id_q, xfer_id_d, slot_q;
  logic [7:0] tick_q, us_q;
  logic xfer_req_q, xfer_req_d, trig_q, trig_d, miss_q, miss_d, slot_rst;
  logic [ENTRY_W-1:0] rd_data;

  // ----------------------------------------------------------------------
  // Entry fields and memory addressing.
  // ----------------------------------------------------------------------
  wire searching = (state_q == ST_SRCH_RD) || (state_q == ST_SRCH_CHK);
  wire [ADDR_W-1:0] rd_addr = searching ? scan_q : pc_q;
  wire [OP_W-1:0] op_w = rd_data[OP_LSB +: OP_W];
  wire [LABEL_W-1:0] label_w = rd_data[LABEL_LSB +: LABEL_W];
  wire [PARAM_W-1:0] param_w = rd_data[PARAM_LSB +: PARAM_W];
  wire exec = (state_q == ST_DECODE);
  wire scan_last = (scan_q == {ADDR_W{1'b1}});

  // The list spans the whole memory; frames are bounded only by its size.
  bcis_list_mem u_list (
    .clk(clk),
    .wr_en(host_wr_en),
    .wr_addr(host_wr_addr),
    .wr_data(host_wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------------
  // Timers: pause tick and minor frame slot.
  // ----------------------------------------------------------------------
  wire tick_end = (tick_q == PAUSE_UNIT_CYC - 8'h01);
  wire us_end = (us_q == SLOT_UNIT_CYC - 8'h01);
  // Compare with >= so a shortened period still closes the current slot.
  wire slot_pulse = us_end &&
    ({1'b0, slot_q} + 17'h00001 >= {1'b0, period_q});

  // Pause counter runs only while pausing; the slot timer always runs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 8'h00;
      us_q <= 8'h00;
      slot_q <= 16'h0000;
    end else begin
      tick_q <= (state_q != ST_PAUSE || tick_end) ? 8'h00 : tick_q + 8'h01;
      us_q <= (slot_rst || us_end) ? 8'h00 : us_q + 8'h01;
      if (slot_rst || slot_pulse) begin
        slot_q <= 16'h0000;
      end else if (us_end) begin
        slot_q <= slot_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer next-state logic.
  // ----------------------------------------------------------------------
  // A start request overrides any state, including the halted one.
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    ret_d = ret_q;
    scan_d = scan_q;
    target_d = target_q;
    mcnt_d = mcnt_q;
    period_d = period_q;
    units_d = units_q;
    xfer_req_d = 1'b0;
    xfer_id_d = xfer_id_q;
    trig_d = 1'b0;
    miss_d = miss_q;
    slot_rst = 1'b0;
    if (start) begin
      state_d = ST_FETCH;
      pc_d = start_addr;
      mcnt_d = frame_cnt_init;
      period_d = frame_time_init;
      miss_d = 1'b0;
      slot_rst = 1'b1;
    end else begin
      case (state_q)
        ST_FETCH: begin
          state_d = ST_DECODE;
        end
        ST_DECODE: begin
          pc_d = adv(pc_q, 16'h0000);
          state_d = ST_FETCH;
          case (op_w)
            OP_RUN_TRANSFER: begin
              xfer_req_d = 1'b1;
              xfer_id_d = param_w;
              state_d = ST_XFER_WAIT;
            end
            OP_CALL_SUBTABLE: begin
              ret_d = adv(pc_q, 16'h0000);
              target_d = param_w;
              scan_d = '0;
              state_d = ST_SRCH_RD;
            end
            OP_RETURN_SUBTABLE: begin
              pc_d = ret_q;
            end
            OP_ABSOLUTE_BRANCH: begin
              target_d = param_w;
              scan_d = '0;
              state_d = ST_SRCH_RD;
            end
            OP_RELATIVE_BRANCH: begin
              pc_d = adv(pc_q, param_w);
            end
            OP_AWAIT_TRIGGER_IN: begin
              state_d = ST_TRIG_WAIT;
            end
            OP_PULSE_TRIGGER_OUT: begin
              trig_d = 1'b1;
            end
            OP_COUNT_DOWN_BRANCH: begin
              // An exhausted counter stays at zero and keeps branching.
              mcnt_d = (mcnt_q == 16'h0000) ? 16'h0000 : mcnt_q - 16'h0001;
              if (mcnt_q <= 16'h0001) begin
                target_d = param_w;
                scan_d = '0;
                state_d = ST_SRCH_RD;
              end
            end
            OP_AWAIT_NEXT_SLOT: begin
              state_d = ST_SLOT_WAIT;
            end
            OP_STOP_CONTROLLER: begin
              pc_d = pc_q;
              state_d = ST_HALT;
            end
            OP_TIMED_PAUSE: begin
              if (param_w != 16'h0000) begin
                units_d = param_w;
                state_d = ST_PAUSE;
              end
            end
            OP_SET_SLOT_PERIOD: begin
              period_d = param_w;
            end
            OP_RESTART_MAJOR_CYCLE: begin
              mcnt_d = frame_cnt_init;
              slot_rst = 1'b1;
            end
            default: begin
              // Zero and unknown opcodes fall through as no-operations.
              state_d = ST_FETCH;
            end
          endcase
        end
        ST_XFER_WAIT: begin
          if (xfer_done) begin
            state_d = ST_FETCH;
          end
        end
        ST_TRIG_WAIT: begin
          if (trigger_in) begin
            state_d = ST_FETCH;
          end
        end
        ST_SLOT_WAIT: begin
          if (slot_pulse) begin
            state_d = ST_FETCH;
          end
        end
        ST_PAUSE: begin
          if (tick_end) begin
            units_d = units_q - 16'h0001;
            if (units_q == 16'h0001) begin
              state_d = ST_FETCH;
            end
          end
        end
        ST_SRCH_RD: begin
          state_d = ST_SRCH_CHK;
        end
        ST_SRCH_CHK: begin
          // Linear scan: the first entry whose label matches wins.
          if (label_w == target_q) begin
            pc_d = scan_q;
            state_d = ST_FETCH;
          end else if (scan_last) begin
            miss_d = 1'b1;
            state_d = ST_HALT;
          end else begin
            scan_d = scan_q + ADDR_W'(1);
            state_d = ST_SRCH_RD;
          end
        end
        ST_IDLE, ST_HALT: begin
          state_d = state_q;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pc_q <= '0;
      ret_q <= '0;
      scan_q <= '0;
      target_q <= '0;
      mcnt_q <= COUNT_RST;
      period_q <= PERIOD_RST;
      units_q <= 16'h0000;
      xfer_req_q <= 1'b0;
      xfer_id_q <= 16'h0000;
      trig_q <= 1'b0;
      miss_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      ret_q <= ret_d;
      scan_q <= scan_d;
      target_q <= target_d;
      mcnt_q <= mcnt_d;
      period_q <= period_d;
      units_q <= units_d;
      xfer_req_q <= xfer_req_d;
      xfer_id_q <= xfer_id_d;
      trig_q <= trig_d;
      miss_q <= miss_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign xfer_req = xfer_req_q;
  assign xfer_id = xfer_id_q;
  assign trigger_out = trig_q;
  assign label_miss = miss_q;
  assign instr_addr = pc_q;
  assign halted = (state_q == ST_HALT);
  assign running = (state_q != ST_HALT) && (state_q != ST_IDLE);

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  nop_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !start && rd_data == '0 |=>
      state_q == ST_FETCH && pc_q == $past(pc_q) + ADDR_W'(1))
    else $error("zero entry did not advance");

  xfer_issue_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !start && op_w == OP_RUN_TRANSFER |=>
      xfer_req && xfer_id == $past(param_w) && state_q == ST_XFER_WAIT)
    else $error("transfer not issued");

  call_save_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !start && op_w == OP_CALL_SUBTABLE |=>
      ret_q == $past(pc_q) + ADDR_W'(1) && state_q == ST_SRCH_RD)
    else $error("call did not save return");

  return_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !start && op_w == OP_RETURN_SUBTABLE |=> pc_q == $past(ret_q))
    else $error("return went to wrong entry");

  skip_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !start && op_w == OP_RELATIVE_BRANCH |=>
      pc_q == $past(pc_q) + $past(param_w[ADDR_W-1:0]) + ADDR_W'(1))
    else $error("skip landed wrong");

  trig_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_TRIG_WAIT && !trigger_in && !start |=>
      state_q == ST_TRIG_WAIT)
    else $error("left trigger wait early");

  strobe_pulse_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    exec && !start && op_w == OP_PULSE_TRIGGER_OUT |=>
      trigger_out ##1 !trigger_out)
    else $error("strobe not one cycle");

  countdown_jump_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    exec && !start && op_w == OP_COUNT_DOWN_BRANCH && mcnt_q == 16'h0001
      |=> state_q == ST_SRCH_RD && mcnt_q == 16'h0000)
    else $error("count-down did not branch");

  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    halted && !start |=> halted && $stable(pc_q))
    else $error("halted sequencer moved");

  period_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && !start && op_w == OP_SET_SLOT_PERIOD |=>
      period_q == $past(param_w))
    else $error("slot period not updated");

endmodule : bcis_sequencer

// [sim/bcis_xfer_model.sv]
// Transfer engine model that answers the sequencer's transfer requests.
`timescale 1ns/100ps
module bcis_xfer_model (
  input wire logic clk,
  input wire logic xfer_req,
  input wire logic [15:0] xfer_id,
  input wire logic [31:0] lat,
  output logic xfer_done
);
  // ----------------------------------------------------------------------
  // Request log and delayed completion.
  // ----------------------------------------------------------------------
  logic [15:0] ids[$];
  int times[$];
  int cyc = 0;
  int wait_c = 0;
  logic pend = 1'b0;

  initial xfer_done = 1'b0;

  // Each request is logged with its cycle; done follows lat + 1 cycles later,
  // so a slow engine shows whether the sequencer really waits for it.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    xfer_done <= 1'b0;
    if (xfer_req === 1'b1) begin
      ids.push_back(xfer_id);
      times.push_back(cyc);
      wait_c <= lat;
      pend <= 1'b1;
    end else if (pend) begin
      if (wait_c == 0) begin
        xfer_done <= 1'b1;
        pend <= 1'b0;
      end else begin
        wait_c <= wait_c - 1;
      end
    end
  end
endmodule : bcis_xfer_model

// [sim/bc_instruction_sequencer_tb_top.sv]
// Self-checking testbench of the instruction sequencer.
`timescale 1ns/100ps
module bc_instruction_sequencer_tb_top;
  import bcis_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic host_wr_en = 1'b0;
  logic trigger_in = 1'b0;
  logic [ADDR_W-1:0] start_addr = '0;
  logic [ADDR_W-1:0] host_wr_addr = '0;
  logic [ADDR_W-1:0] instr_addr;
  logic [15:0] frame_cnt_init = 16'h0000;
  logic [15:0] frame_time_init = 16'h0004;
  logic [15:0] xfer_id;
  logic [ENTRY_W-1:0] host_wr_data = '0;
  logic xfer_req, xfer_done, trigger_out, running, halted, label_miss;
  int num_errors = 0;
  int n_tests = 0;
  int n_strobe = 0;
  int lat = 0;

  // ----------------------------------------------------------------------
  // Clock, design and partner.
  // ----------------------------------------------------------------------
  always #2 clk = ~clk;

  // Strobe cycles are counted so a pulse longer than one cycle shows.
  always @(posedge clk) if (trigger_out === 1'b1) n_strobe <= n_strobe + 1;

  bcis_sequencer i_dut (.clk(clk), .arst_n(arst_n), .start(start),
    .start_addr(start_addr), .frame_cnt_init(frame_cnt_init),
    .frame_time_init(frame_time_init), .host_wr_en(host_wr_en),
    .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data),
    .xfer_req(xfer_req), .xfer_id(xfer_id), .xfer_done(xfer_done),
    .trigger_in(trigger_in), .trigger_out(trigger_out), .running(running),
    .halted(halted), .label_miss(label_miss), .instr_addr(instr_addr));

  bcis_xfer_model i_model (.clk(clk), .xfer_req(xfer_req),
    .xfer_id(xfer_id), .lat(lat), .xfer_done(xfer_done));

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got,
        lo, hi);
    end
  endtask : cmp_rng

  // Writes are held back to back; the caller drops the strobe at the end.
  task automatic put(input int a, input logic [7:0] op,
                     input logic [15:0] lb, input logic [15:0] pr);
    host_wr_addr = ADDR_W'(a);
    host_wr_data = {op, lb, pr};
    host_wr_en = 1'b1;
    step;
  endtask : put

  // Every entry is zeroed first, so stale tables read as no-operations.
  task automatic clear_list;
    for (int i = 0; i < 1024; i++) put(i, OP_NOP, 16'h0000, 16'h0000);
  endtask : clear_list

  task automatic go(input int a);
    host_wr_en = 1'b0;
    i_model.ids.delete();
    i_model.times.delete();
    start_addr = ADDR_W'(a);
    start = 1'b1;
    step;
    start = 1'b0;
  endtask : go

  // After a halt nothing more may be fetched or requested.
  task automatic wait_halt(input int bound);
    int i;
    int n;
    logic [ADDR_W-1:0] a;
    for (i = 0; i < bound && halted !== 1'b1; i++) step;
    if (i >= bound) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, halted, 1);
      tally_and_finish;
    end
    n = i_model.ids.size();
    a = instr_addr;
    repeat (20) step;
    cmp(16'(i_model.ids.size()), 16'(n));
    cmp(16'(instr_addr), 16'(a));
    cmp(16'(running), 16'h0000);
  endtask : wait_halt

  task automatic chk_ids(input logic [15:0] e[$]);
    cmp(16'(i_model.ids.size()), 16'(e.size()));
    foreach (e[i]) if (i < i_model.ids.size()) cmp(i_model.ids[i], e[i]);
  endtask : chk_ids

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  // Nop, transfers, skip, call and return, jump, stop; slow partner.
  task automatic sc_flow;
    lat = 3;
    clear_list;
    put(1, OP_RUN_TRANSFER, 16'h1111, 16'h0001);
    put(2, OP_RUN_TRANSFER, 16'h0000, 16'h0002);
    put(3, OP_RELATIVE_BRANCH, 16'h0000, 16'h0001);
    put(4, OP_RUN_TRANSFER, 16'h0000, 16'h0009);
    put(5, OP_CALL_SUBTABLE, 16'h0000, 16'h2222);
    put(6, OP_RUN_TRANSFER, 16'h0000, 16'h0005);
    put(7, OP_ABSOLUTE_BRANCH, 16'h0000, 16'h3333);
    put(8, OP_RUN_TRANSFER, 16'h0000, 16'h0008);
    put(10, OP_RUN_TRANSFER, 16'h2222, 16'h0003);
    put(11, OP_RETURN_SUBTABLE, 16'h0000, 16'h0000);
    put(20, OP_RUN_TRANSFER, 16'h3333, 16'h0007);
    put(21, OP_STOP_CONTROLLER, 16'h0000, 16'h0000);
    go(0);
    wait_halt(6000);
    chk_ids('{1, 2, 3, 5, 7});
    cmp(16'(label_miss), 16'h0000);
    cmp(16'(instr_addr), 16'h0015);
  endtask : sc_flow

  // Strobe out, then a stall that only the trigger input ends.
  task automatic sc_trig;
    lat = 0;
    clear_list;
    put(0, OP_PULSE_TRIGGER_OUT, 16'h0000, 16'h0000);
    put(1, OP_AWAIT_TRIGGER_IN, 16'h0000, 16'h0000);
    put(2, OP_RUN_TRANSFER, 16'h0000, 16'h0004);
    put(3, OP_STOP_CONTROLLER, 16'h0000, 16'h0000);
    n_strobe = 0;
    go(0);
    repeat (30) step;
    cmp(16'(n_strobe), 16'h0001);
    cmp(16'(i_model.ids.size()), 16'h0000);
    cmp(16'(running), 16'h0001);
    trigger_in = 1'b1;
    step;
    trigger_in = 1'b0;
    wait_halt(200);
    chk_ids('{4});
  endtask : sc_trig

  // A pause of two units between two transfers.
  task automatic sc_pause;
    int g;
    clear_list;
    put(0, OP_RUN_TRANSFER, 16'h0000, 16'h0001);
    put(1, OP_TIMED_PAUSE, 16'h0000, 16'h0002);
    put(2, OP_RUN_TRANSFER, 16'h0000, 16'h0002);
    put(3, OP_STOP_CONTROLLER, 16'h0000, 16'h0000);
    go(0);
    wait_halt(1000);
    chk_ids('{1, 2});
    g = i_model.times[1] - i_model.times[0];
    cmp_rng(g, 2 * PAUSE_UNIT_CYC_I, 2 * PAUSE_UNIT_CYC_I + 12);
  endtask : sc_pause

  // Count-down loop of two passes, then a reload by restart-major.
  task automatic sc_count;
    frame_cnt_init = 16'h0002;
    clear_list;
    put(0, OP_RUN_TRANSFER, 16'h1111, 16'h0001);
    put(1, OP_COUNT_DOWN_BRANCH, 16'h0000, 16'h4444);
    put(2, OP_ABSOLUTE_BRANCH, 16'h0000, 16'h1111);
    put(10, OP_RUN_TRANSFER, 16'h4444, 16'h0006);
    put(11, OP_RESTART_MAJOR_CYCLE, 16'h0000, 16'h0000);
    put(12, OP_COUNT_DOWN_BRANCH, 16'h0000, 16'h5555);
    put(13, OP_RUN_TRANSFER, 16'h0000, 16'h0007);
    put(14, OP_STOP_CONTROLLER, 16'h0000, 16'h0000);
    put(20, OP_RUN_TRANSFER, 16'h5555, 16'h0008);
    put(21, OP_STOP_CONTROLLER, 16'h0000, 16'h0000);
    go(0);
    wait_halt(6000);
    chk_ids('{1, 1, 6, 7});
  endtask : sc_count

  // Slots of 4 us, then 2 us after a period change in mid-run.
  task automatic sc_slot;
    int t0;
    clear_list;
    put(0, OP_AWAIT_NEXT_SLOT, 16'h0000, 16'h0000);
    put(1, OP_RUN_TRANSFER, 16'h0000, 16'h0001);
    put(2, OP_SET_SLOT_PERIOD, 16'h0000, 16'h0002);
    put(3, OP_AWAIT_NEXT_SLOT, 16'h0000, 16'h0000);
    put(4, OP_RUN_TRANSFER, 16'h0000, 16'h0002);
    put(5, OP_AWAIT_NEXT_SLOT, 16'h0000, 16'h0000);
    put(6, OP_RUN_TRANSFER, 16'h0000, 16'h0003);
    put(7, OP_STOP_CONTROLLER, 16'h0000, 16'h0000);
    t0 = i_model.cyc;
    go(0);
    wait_halt(6000);
    chk_ids('{1, 2, 3});
    cmp_rng(i_model.times[0] - t0, 996, 1012);
    cmp_rng(i_model.times[2] - i_model.times[1], 496, 504);
  endtask : sc_slot

  // A jump to a label that no entry carries.
  task automatic sc_miss;
    clear_list;
    put(0, OP_ABSOLUTE_BRANCH, 16'h0000, 16'h7777);
    go(0);
    wait_halt(4000);
    cmp(16'(label_miss), 16'h0001);
  endtask : sc_miss

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) step;
    arst_n = 1'b1;
    repeat (3) step;
    sc_flow;
    sc_trig;
    sc_pause;
    sc_count;
    sc_slot;
    sc_miss;
    tally_and_finish;
  end
endmodule : bc_instruction_sequencer_tb_top
